// ### hdl/ccl_pkg.sv
// Constants, types and helpers for the comparator control logic
package ccl_pkg;

   // Bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] OFS_CTRL_A1 = 4'h0;
   localparam logic [3:0] OFS_CTRL_A2 = 4'h1;
   localparam logic [3:0] OFS_CTRL_B1 = 4'h2;
   localparam logic [3:0] OFS_CTRL_B2 = 4'h3;
   localparam logic [3:0] OFS_MIRROR = 4'h4;
   localparam logic [3:0] OFS_IRQ_STATUS = 4'h5;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
   localparam logic [3:0] OFS_PORT = 4'h7;
   localparam logic [3:0] OFS_ANALOG_SEL = 4'h8;
   localparam logic [3:0] OFS_PIN_DIR = 4'h9;

   // Field positions, control register A
   localparam int BIT_ON = 7;
   localparam int BIT_RESULT = 6;
   localparam int BIT_PIN_OE = 5;
   localparam int BIT_INVERT = 4;
   localparam int BIT_SPEED = 2;
   localparam int BIT_HYST = 1;
   localparam int BIT_SYNC = 0;

   // Field positions, control register B
   localparam int BIT_RISE = 7;
   localparam int BIT_FALL = 6;
   localparam int POS_LSB = 4;
   localparam int NEG_LSB = 0;

   // Field positions, mirror and interrupt registers
   localparam int BIT_CMP1 = 0;
   localparam int BIT_CMP2 = 1;

   // Positive channel codes
   localparam logic [1:0] POS_CH_PIN = 2'h0;
   localparam logic [1:0] POS_CH_DAC = 2'h1;
   localparam logic [1:0] POS_CH_FIXED_REF = 2'h2;
   localparam logic [1:0] POS_CH_GROUND = 2'h3;

   // Values after reset
   localparam logic [7:0] CTRL_A_RST = 8'h04;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [1:0] PIN_DIR_RST = 2'h3;
   localparam logic [7:0] ANALOG_SEL_RST = 8'hff;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int INSTR_CYCLE_CLKS = 4;
   localparam logic [1:0] INSTR_CNT_LAST = 2'(INSTR_CYCLE_CLKS - 1);

   typedef struct packed {
      logic cmp_on;
      logic cmp_pin_out_en;
      logic cmp_invert;
      logic cmp_speed_sel;
      logic cmp_hyst_en;
      logic cmp_sync_sel;
   } ccl_ctrl_a_t;

   typedef struct packed {
      logic rise_flag_en;
      logic fall_flag_en;
      logic [1:0] pos_channel_sel;
      logic [1:0] neg_channel_sel;
   } ccl_ctrl_b_t;

   typedef struct packed {
      logic power_on;
      logic speed_sel;
      logic hyst_en;
      logic [3:0] pos_switch;
      logic [3:0] neg_switch;
   } ccl_ana_t;

   function automatic ccl_ctrl_a_t ccl_unpack_a(input logic [7:0] d);
      ccl_ctrl_a_t c;
      c.cmp_on = d[BIT_ON];
      c.cmp_pin_out_en = d[BIT_PIN_OE];
      c.cmp_invert = d[BIT_INVERT];
      c.cmp_speed_sel = d[BIT_SPEED];
      c.cmp_hyst_en = d[BIT_HYST];
      c.cmp_sync_sel = d[BIT_SYNC];
      return c;
   endfunction

   function automatic logic [7:0] ccl_pack_a(input ccl_ctrl_a_t c, input logic res);
      logic [7:0] d;
      d = 8'h00;
      d[BIT_ON] = c.cmp_on;
      d[BIT_RESULT] = res;
      d[BIT_PIN_OE] = c.cmp_pin_out_en;
      d[BIT_INVERT] = c.cmp_invert;
      d[BIT_SPEED] = c.cmp_speed_sel;
      d[BIT_HYST] = c.cmp_hyst_en;
      d[BIT_SYNC] = c.cmp_sync_sel;
      return d;
   endfunction

   function automatic ccl_ctrl_b_t ccl_unpack_b(input logic [7:0] d);
      ccl_ctrl_b_t c;
      c.rise_flag_en = d[BIT_RISE];
      c.fall_flag_en = d[BIT_FALL];
      c.pos_channel_sel = d[POS_LSB +: 2];
      c.neg_channel_sel = d[NEG_LSB +: 2];
      return c;
   endfunction

   function automatic logic [7:0] ccl_pack_b(input ccl_ctrl_b_t c);
      logic [7:0] d;
      d = 8'h00;
      d[BIT_RISE] = c.rise_flag_en;
      d[BIT_FALL] = c.fall_flag_en;
      d[POS_LSB +: 2] = c.pos_channel_sel;
      d[NEG_LSB +: 2] = c.neg_channel_sel;
      return d;
   endfunction

   // Analogue switch select, all open while not enabled
   function automatic logic [3:0] ccl_onehot4(input logic [1:0] sel, input logic en);
      logic [3:0] oh;
      oh = 4'h0;
      oh[sel] = en;
      return oh;
   endfunction

endpackage

// ### hdl/ccl_cmp_unit.sv
// One comparator: gating, polarity, result latch, edge detect, sync path
`timescale 1ns/10ps
module ccl_cmp_unit (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Comparison and configuration
   input wire logic raw_in,
   input wire ccl_pkg::ccl_ctrl_a_t cfg_a_in,
   input wire ccl_pkg::ccl_ctrl_b_t cfg_b_in,
   // Timing strobes
   input wire logic instr_tick_in,
   input wire logic tmr_fall_in,
   // Results
   output logic result_out,
   output logic ext_result_out,
   output logic edge_out
);

   logic live;
   logic result_ff;
   logic ext_ff;
   logic edge_ff;
   logic nxt_edge;

   // Disabled comparator output is invalid, held low before polarity
   assign live = (cfg_a_in.cmp_on & raw_in) ^ cfg_a_in.cmp_invert;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         result_ff <= 1'b0;
      end else if (instr_tick_in) begin
         result_ff <= live;
      end
   end

   // Polarity or enable toggles move live too, so they raise edges
   always_comb begin
      nxt_edge = 1'b0;
      if (instr_tick_in && (live != result_ff)) begin
         nxt_edge = (live & cfg_b_in.rise_flag_en) | (~live & cfg_b_in.fall_flag_en);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         edge_ff <= 1'b0;
      end else begin
         edge_ff <= nxt_edge;
      end
   end

   // Unsynchronised path still passes one flop, tracking every clock
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ext_ff <= 1'b0;
      end else if (!cfg_a_in.cmp_sync_sel || tmr_fall_in) begin
         ext_ff <= live;
      end
   end

   assign result_out = result_ff;
   assign ext_result_out = ext_ff;
   assign edge_out = edge_ff;

endmodule // ccl_cmp_unit

// ### hdl/ccl_top.sv
// Comparator control logic: registers, two comparators, pins and interrupt
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module ccl_top (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   // Analogue comparison outcomes
   input wire logic [1:0] cmp_raw_in,
   // Timer clock source and timer gate results
   input wire logic timer_clk_in,
   output logic [1:0] timer_gate_src_out,
   // Port pins
   input wire logic [7:0] port_pins_in,
   output logic [1:0] cmp_pin_out,
   output logic [1:0] cmp_pin_oe_out,
   // Analogue front-end control
   output ccl_pkg::ccl_ana_t [1:0] ana_ctrl_out,
   // Interrupt
   output logic irq_out
);

   localparam int SYNC_W = 11;

   // Synchroniser chain: pins, raw comparisons, timer clock
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync1_ff;
   logic [SYNC_W-1:0] sync2_ff;
   logic [SYNC_W-1:0] sync3_ff;
   logic [SYNC_W-1:0] stable_ff;
   logic [SYNC_W-1:0] nxt_stable;
   logic [7:0] pins_stable;
   logic [1:0] raw_stable;
   logic tmr_stable;
   logic tmr_prev_ff;
   logic tmr_fall;

   // Instruction cycle timing
   logic [1:0] instr_cnt_ff;
   logic instr_tick_ff;

   // Registers
   ccl_pkg::ccl_ctrl_a_t [1:0] ctrl_a_ff;
   ccl_pkg::ccl_ctrl_b_t [1:0] ctrl_b_ff;
   logic [1:0] irq_status_ff;
   logic [1:0] nxt_irq_status;
   logic [1:0] irq_mask_ff;
   logic [1:0] pin_dir_ff;
   logic [7:0] analog_sel_ff;
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;
   logic irq_ff;

   // Comparator results
   logic [1:0] result;
   logic [1:0] ext_result;
   logic [1:0] edge_evt;

   // Outputs
   logic [1:0] pin_ff;
   logic [1:0] pin_oe_ff;
   logic [1:0] gate_src_ff;
   ccl_pkg::ccl_ana_t [1:0] ana_ff;

   // Write decode
   logic wr_ctrl_a1;
   logic wr_ctrl_a2;
   logic wr_ctrl_b1;
   logic wr_ctrl_b2;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic wr_analog_sel;
   logic wr_pin_dir;

   assign sync_in = {timer_clk_in, cmp_raw_in, port_pins_in};

   // Three stages; the first is read only by the second
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end else begin
         sync1_ff <= sync_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // A bit moves only once stages two and three agree
   always_comb begin
      nxt_stable = (sync2_ff & sync3_ff) | (stable_ff & (sync2_ff ^ sync3_ff));
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         stable_ff <= '0;
      end else begin
         stable_ff <= nxt_stable;
      end
   end

   assign pins_stable = stable_ff[7:0];
   assign raw_stable = stable_ff[9:8];
   assign tmr_stable = stable_ff[10];

   // Falling edge of the timer clock source
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         tmr_prev_ff <= 1'b0;
      end else begin
         tmr_prev_ff <= tmr_stable;
      end
   end

   assign tmr_fall = tmr_prev_ff & ~tmr_stable;

   // One tick per instruction cycle
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         instr_cnt_ff <= 2'h0;
         instr_tick_ff <= 1'b0;
      end else begin
         if (instr_cnt_ff == ccl_pkg::INSTR_CNT_LAST) begin
            instr_cnt_ff <= 2'h0;
         end else begin
            instr_cnt_ff <= instr_cnt_ff + 2'h1;
         end
         instr_tick_ff <= (instr_cnt_ff == ccl_pkg::INSTR_CNT_LAST);
      end
   end

   assign wr_ctrl_a1 = wr_en_in && (addr_in == ccl_pkg::OFS_CTRL_A1);
   assign wr_ctrl_a2 = wr_en_in && (addr_in == ccl_pkg::OFS_CTRL_A2);
   assign wr_ctrl_b1 = wr_en_in && (addr_in == ccl_pkg::OFS_CTRL_B1);
   assign wr_ctrl_b2 = wr_en_in && (addr_in == ccl_pkg::OFS_CTRL_B2);
   assign wr_irq_status = wr_en_in && (addr_in == ccl_pkg::OFS_IRQ_STATUS);
   assign wr_irq_mask = wr_en_in && (addr_in == ccl_pkg::OFS_IRQ_MASK);
   assign wr_analog_sel = wr_en_in && (addr_in == ccl_pkg::OFS_ANALOG_SEL);
   assign wr_pin_dir = wr_en_in && (addr_in == ccl_pkg::OFS_PIN_DIR);

   // Control A; result and bit 3 are not stored, so writes to them vanish
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_a_ff[0] <= ccl_pkg::ccl_unpack_a(ccl_pkg::CTRL_A_RST);
         ctrl_a_ff[1] <= ccl_pkg::ccl_unpack_a(ccl_pkg::CTRL_A_RST);
      end else begin
         if (wr_ctrl_a1) begin
            ctrl_a_ff[0] <= ccl_pkg::ccl_unpack_a(wr_data_in);
         end
         if (wr_ctrl_a2) begin
            ctrl_a_ff[1] <= ccl_pkg::ccl_unpack_a(wr_data_in);
         end
      end
   end

   // Control B; bits 3:2 are not stored
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl_b_ff[0] <= ccl_pkg::ccl_unpack_b(ccl_pkg::CTRL_B_RST);
         ctrl_b_ff[1] <= ccl_pkg::ccl_unpack_b(ccl_pkg::CTRL_B_RST);
      end else begin
         if (wr_ctrl_b1) begin
            ctrl_b_ff[0] <= ccl_pkg::ccl_unpack_b(wr_data_in);
         end
         if (wr_ctrl_b2) begin
            ctrl_b_ff[1] <= ccl_pkg::ccl_unpack_b(wr_data_in);
         end
      end
   end

   // Pin direction: 1 is input, so pins start undriven
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pin_dir_ff <= ccl_pkg::PIN_DIR_RST;
      end else if (wr_pin_dir) begin
         pin_dir_ff <= wr_data_in[1:0];
      end
   end

   // Analogue input select per port pin
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         analog_sel_ff <= ccl_pkg::ANALOG_SEL_RST;
      end else if (wr_analog_sel) begin
         analog_sel_ff <= wr_data_in;
      end
   end

   ccl_cmp_unit u_cmp1 (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .raw_in(raw_stable[0]),
      .cfg_a_in(ctrl_a_ff[0]),
      .cfg_b_in(ctrl_b_ff[0]),
      .instr_tick_in(instr_tick_ff),
      .tmr_fall_in(tmr_fall),
      .result_out(result[0]),
      .ext_result_out(ext_result[0]),
      .edge_out(edge_evt[0])
   );

   ccl_cmp_unit u_cmp2 (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .raw_in(raw_stable[1]),
      .cfg_a_in(ctrl_a_ff[1]),
      .cfg_b_in(ctrl_b_ff[1]),
      .instr_tick_in(instr_tick_ff),
      .tmr_fall_in(tmr_fall),
      .result_out(result[1]),
      .ext_result_out(ext_result[1]),
      .edge_out(edge_evt[1])
   );

   // Sticky edge flags; an edge in the clearing cycle wins
   always_comb begin
      nxt_irq_status = irq_status_ff;
      if (wr_irq_status) begin
         nxt_irq_status = irq_status_ff & ~wr_data_in[1:0];
      end
      nxt_irq_status = nxt_irq_status | edge_evt;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_status_ff <= 2'h0;
      end else begin
         irq_status_ff <= nxt_irq_status;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_mask_ff <= ccl_pkg::IRQ_MASK_RST;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= wr_data_in[1:0];
      end
   end

   // Level output, from the next flags, in step with the status register
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(nxt_irq_status & irq_mask_ff);
      end
   end

   // Pin routing ignores the enable bit; the pin output enable and direction together gate the driver
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         pin_ff <= 2'h0;
         pin_oe_ff <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            pin_ff[i] <= ctrl_a_ff[i].cmp_pin_out_en & ext_result[i];
            pin_oe_ff[i] <= ctrl_a_ff[i].cmp_pin_out_en & ~pin_dir_ff[i];
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         gate_src_ff <= 2'h0;
      end else begin
         gate_src_ff <= ext_result;
      end
   end

   // Analogue front end; switches open while disabled
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ana_ff <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            ana_ff[i].power_on <= ctrl_a_ff[i].cmp_on;
            ana_ff[i].speed_sel <= ctrl_a_ff[i].cmp_speed_sel;
            ana_ff[i].hyst_en <= ctrl_a_ff[i].cmp_hyst_en;
            ana_ff[i].pos_switch <= ccl_pkg::ccl_onehot4(ctrl_b_ff[i].pos_channel_sel,
               ctrl_a_ff[i].cmp_on);
            ana_ff[i].neg_switch <= ccl_pkg::ccl_onehot4(ctrl_b_ff[i].neg_channel_sel,
               ctrl_a_ff[i].cmp_on);
         end
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      nxt_rd_data = 8'h00;
      if (rd_en_in) begin
         case (addr_in)
            ccl_pkg::OFS_CTRL_A1: begin
               nxt_rd_data = ccl_pkg::ccl_pack_a(ctrl_a_ff[0], result[0]);
            end
            ccl_pkg::OFS_CTRL_A2: begin
               nxt_rd_data = ccl_pkg::ccl_pack_a(ctrl_a_ff[1], result[1]);
            end
            ccl_pkg::OFS_CTRL_B1: begin
               nxt_rd_data = ccl_pkg::ccl_pack_b(ctrl_b_ff[0]);
            end
            ccl_pkg::OFS_CTRL_B2: begin
               nxt_rd_data = ccl_pkg::ccl_pack_b(ctrl_b_ff[1]);
            end
            ccl_pkg::OFS_MIRROR: begin
               nxt_rd_data[ccl_pkg::BIT_CMP1] = result[0];
               nxt_rd_data[ccl_pkg::BIT_CMP2] = result[1];
            end
            ccl_pkg::OFS_IRQ_STATUS: begin
               nxt_rd_data[1:0] = irq_status_ff;
            end
            ccl_pkg::OFS_IRQ_MASK: begin
               nxt_rd_data[1:0] = irq_mask_ff;
            end
            ccl_pkg::OFS_PORT: begin
               nxt_rd_data = pins_stable & ~analog_sel_ff;
            end
            ccl_pkg::OFS_ANALOG_SEL: begin
               nxt_rd_data = analog_sel_ff;
            end
            ccl_pkg::OFS_PIN_DIR: begin
               nxt_rd_data[1:0] = pin_dir_ff;
            end
            default: begin
               nxt_rd_data = 8'h00;
            end
         endcase
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rd_data_ff <= 8'h00;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   assign rd_data_out = rd_data_ff;
   assign timer_gate_src_out = gate_src_ff;
   assign cmp_pin_out = pin_ff;
   assign cmp_pin_oe_out = pin_oe_ff;
   assign ana_ctrl_out = ana_ff;
   assign irq_out = irq_ff;

endmodule // ccl_top

// ### tb/ccl_top_props.sv
// Port-level checker for the comparator control logic
`timescale 1ns/10ps
module ccl_top_props (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] rd_data_out,
   // Timer, pins, front end, interrupt
   input wire logic timer_clk_in,
   input wire logic [1:0] timer_gate_src_out,
   input wire logic [1:0] cmp_pin_oe_out,
   input wire ccl_pkg::ccl_ana_t [1:0] ana_ctrl_out,
   input wire logic irq_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   // Shadow of the few register bits the port relations depend on
   logic [1:0] oen_ff;
   logic [1:0] dir_ff;
   logic [1:0] mask_ff;
   logic sync_ff;
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         oen_ff <= 2'h0;
         dir_ff <= 2'h3;
         mask_ff <= 2'h0;
         sync_ff <= 1'b0;
      end else if (wr_en_in) begin
         if (addr_in == ccl_pkg::OFS_CTRL_A1) begin
            oen_ff[0] <= wr_data_in[5];
            sync_ff <= wr_data_in[0];
         end
         if (addr_in == ccl_pkg::OFS_CTRL_A2) oen_ff[1] <= wr_data_in[5];
         if (addr_in == ccl_pkg::OFS_PIN_DIR) dir_ff <= wr_data_in[1:0];
         if (addr_in == ccl_pkg::OFS_IRQ_MASK) mask_ff <= wr_data_in[1:0];
      end
   end

   property p_rd_quiet;
      !$past(rd_en_in) |-> rd_data_out == 8'h00;
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
   property p_unmapped;
      $past(rd_en_in) && $past(addr_in) > 4'h9 |-> rd_data_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_a_gap;
      $past(rd_en_in) && $past(addr_in) <= 4'h1 |-> rd_data_out[3] == 1'b0;
   endproperty
   a_a_gap: assert property (p_a_gap) else $error("control A bit 3 set");
   property p_b_gap;
      $past(rd_en_in) && $past(addr_in[3:1]) == 3'h1 |-> rd_data_out[3:2] == 2'h0;
   endproperty
   a_b_gap: assert property (p_b_gap) else $error("control B bits 3:2 set");
   property p_mirror_gap;
      $past(rd_en_in) && $past(addr_in) == 4'h4 |-> rd_data_out[7:2] == 6'h00;
   endproperty
   a_mirror_gap: assert property (p_mirror_gap) else $error("mirror upper bits set");
   property p_off;
      !ana_ctrl_out[0].power_on |-> ana_ctrl_out[0].pos_switch == 4'h0
         && ana_ctrl_out[0].neg_switch == 4'h0;
   endproperty
   a_off: assert property (p_off) else $error("switch closed while off");
   property p_onehot;
      ana_ctrl_out[1].power_on |-> $onehot(ana_ctrl_out[1].pos_switch)
         && $onehot(ana_ctrl_out[1].neg_switch);
   endproperty
   a_onehot: assert property (p_onehot) else $error("input select not one-hot");
   property p_oe;
      $stable(oen_ff & ~dir_ff) |-> cmp_pin_oe_out == (oen_ff & ~dir_ff);
   endproperty
   a_oe: assert property (p_oe) else $error("pin drive enable wrong");
   // Twelve quiet cycles cover the timer clock synchroniser and output flops
   property p_sync_hold;
      (sync_ff && timer_clk_in)[*8] ##1 (sync_ff && timer_clk_in)[*4]
         |-> $stable(timer_gate_src_out[0]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync result moved");
   property p_irq_mask;
      (mask_ff == 2'h0)[*3] |-> !irq_out;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

   c_irq: cover property (irq_out);
   c_pin: cover property (cmp_pin_oe_out[0]);
   c_on: cover property (ana_ctrl_out[0].power_on);
endmodule // ccl_top_props

bind ccl_top ccl_top_props u_props (
   .mclk_in(mclk_in),
   .rst_n_in(rst_n_in),
   .addr_in(addr_in),
   .wr_data_in(wr_data_in),
   .wr_en_in(wr_en_in),
   .rd_en_in(rd_en_in),
   .rd_data_out(rd_data_out),
   .timer_clk_in(timer_clk_in),
   .timer_gate_src_out(timer_gate_src_out),
   .cmp_pin_oe_out(cmp_pin_oe_out),
   .ana_ctrl_out(ana_ctrl_out),
   .irq_out(irq_out)
);

// ### tb/test_comparator_control_logic.sv
// Self-checking bench for the comparator control logic
`timescale 1ns/10ps
`define CHK(g, e) num_checks++; if ((g) !== (e)) begin err_total++; \
   $display("Error %0t got %h exp %h", $time, g, e); end
module test_comparator_control_logic;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] addr_in = 4'h0;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_en_in = 1'b0;
   logic rd_en_in = 1'b0;
   logic [7:0] rd_data_out;
   logic [1:0] cmp_raw_in = 2'h0;
   logic timer_clk_in = 1'b0;
   logic [1:0] timer_gate_src_out;
   logic [7:0] port_pins_in = 8'h00;
   logic [1:0] cmp_pin_out;
   logic [1:0] cmp_pin_oe_out;
   ccl_pkg::ccl_ana_t [1:0] ana_ctrl_out;
   logic irq_out;
   int err_total = 0;
   int num_checks = 0;
   logic [31:0] lf = 32'ha44882bd;
   logic [7:0] da;
   logic [7:0] db;
   logic [1:0] rw;

   ccl_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out), .cmp_raw_in(cmp_raw_in), .timer_clk_in(timer_clk_in),
      .timer_gate_src_out(timer_gate_src_out), .port_pins_in(port_pins_in),
      .cmp_pin_out(cmp_pin_out), .cmp_pin_oe_out(cmp_pin_oe_out),
      .ana_ctrl_out(ana_ctrl_out), .irq_out(irq_out));

   always #2.5 mclk_in = ~mclk_in;

   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Control A as read back: bit 3 dropped, bit 6 the live result
   function automatic logic [7:0] ea(input logic [7:0] d, input logic r);
      return (d & 8'hb7) | {1'b0, (d[7] & r) ^ d[4], 6'h00};
   endfunction
   function automatic ccl_pkg::ccl_ana_t ean(input logic [7:0] a, input logic [7:0] b);
      return {a[7], a[2], a[1], a[7] ? 4'h1 << b[5:4] : 4'h0, a[7] ? 4'h1 << b[1:0] : 4'h0};
   endfunction

   task automatic close_out();
      if (err_total == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1'b1;
      @(posedge mclk_in);
      wr_en_in <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      addr_in <= a;
      rd_en_in <= 1'b1;
      @(posedge mclk_in);
      rd_en_in <= 1'b0;
      @(negedge mclk_in);
      `CHK(rd_data_out, e)
      // Back on the rising edge so later stimulus lands there
      @(posedge mclk_in);
   endtask

   initial begin
      #(5 * 100000);
      err_total++;
      close_out();
   end

   initial begin
      tk(16);
      rst_n_in <= 1'b1;
      rc(4'h0, 8'h04);
      rc(4'h1, 8'h04);
      rc(4'h3, 8'h00);
      rc(4'h4, 8'h00);
      rc(4'h8, 8'hff);
      rc(4'h7, 8'h00);
      rc(4'hf, 8'h00);
      for (int i = 0; i < 8; i++) begin
         lf = nx(lf);
         da = lf[7:0];
         db = lf[15:8];
         cmp_raw_in <= lf[17:16];
         wr(ccl_pkg::OFS_CTRL_A1 + 4'(i % 2), da);
         wr(ccl_pkg::OFS_CTRL_B1 + 4'(i % 2), db);
         tk(16);
         rc(ccl_pkg::OFS_CTRL_A1 + 4'(i % 2), ea(da, lf[16 + i % 2]));
         rc(ccl_pkg::OFS_CTRL_B1 + 4'(i % 2), db & 8'hf3);
         `CHK(ana_ctrl_out[i % 2], ean(da, db))
      end
      for (int k = 0; k < 4; k++) begin
         rw = {k[0], k[0]};
         cmp_raw_in <= rw;
         wr(4'h0, {3'h4, k[1], 4'h4});
         wr(4'h1, {3'h4, k[1], 4'h4});
         tk(16);
         rc(4'h4, {6'h00, rw ^ {2{k[1]}}});
         rc(4'h1, {1'b1, k[0] ^ k[1], 1'b0, k[1], 4'h4});
      end
      cmp_raw_in <= 2'h0;
      wr(4'h0, 8'h84);
      wr(4'h2, 8'h80);
      wr(4'h6, 8'h01);
      tk(16);
      wr(4'h5, 8'h03);
      rc(4'h5, 8'h00);
      cmp_raw_in <= 2'h1;
      tk(16);
      rc(4'h5, 8'h01);
      `CHK(irq_out, 1'b1)
      wr(4'h5, 8'h01);
      tk(2);
      rc(4'h5, 8'h00);
      `CHK(irq_out, 1'b0)
      cmp_raw_in <= 2'h0;
      tk(16);
      rc(4'h5, 8'h00);
      wr(4'h2, 8'h40);
      cmp_raw_in <= 2'h1;
      tk(16);
      rc(4'h5, 8'h00);
      cmp_raw_in <= 2'h0;
      tk(16);
      rc(4'h5, 8'h01);
      wr(4'h6, 8'h00);
      wr(4'h0, 8'h04);
      wr(4'h2, 8'hc0);
      tk(16);
      wr(4'h5, 8'h03);
      wr(4'h0, 8'h14);
      tk(16);
      rc(4'h5, 8'h01);
      `CHK(irq_out, 1'b0)
      wr(4'h9, 8'h02);
      wr(4'h0, 8'h34);
      tk(16);
      `CHK(cmp_pin_oe_out, 2'h1)
      `CHK(cmp_pin_out, 2'h1)
      timer_clk_in <= 1'b1;
      wr(4'h0, 8'h25);
      tk(16);
      `CHK(cmp_pin_out, 2'h1)
      `CHK(timer_gate_src_out, 2'h3)
      timer_clk_in <= 1'b0;
      tk(16);
      `CHK(cmp_pin_out, 2'h0)
      `CHK(timer_gate_src_out, 2'h2)
      lf = nx(lf);
      port_pins_in <= lf[7:0];
      wr(4'h8, 8'h0f);
      tk(8);
      rc(4'h7, lf[7:0] & 8'hf0);
      close_out();
   end
endmodule // test_comparator_control_logic
